// File: rtl/ccarx_ctrl.sv
`timescale 1ns/1ps
module ccarx_ctrl (
  // Clock and reset
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0]                     s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output      logic                            s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output      logic                            s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]                      s_axi_bresp,
  output      logic                            s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]                     s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output      logic                            s_axi_arready,
  output      logic [31:0]                     s_axi_rdata,
  output      logic [1:0]                      s_axi_rresp,
  output      logic                            s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  // Receive events from the demodulator (one-cycle pulses)
  input  wire ccarx_pkg::ccarx_event_type      rx_evt,
  // Filter and IF
  output      logic [1:0]                      filter_bw,
  output      logic                            if_300k,
  // Antenna pins
  output      logic [3:0]                      ant_pin_out,
  output      logic [3:0]                      ant_pin_oe,
  input  wire logic [3:0]                      ant_pin_in,
  // Interrupt
  output      logic                            irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  rx_filter_config_q;
  logic [7:0]  assessment_filter_config_q;
  logic [7:0]  assessment_config_one_q;
  logic [7:0]  antenna_pin_control_q;
  logic [2:0]  rx_progress_flags_q;
  logic [ccarx_pkg::IRQ_W-1:0] irq_stat_q;
  logic [ccarx_pkg::IRQ_W-1:0] irq_en_q;
  ccarx_pkg::ccarx_state_type  state_q;
  logic [1:0]  filter_bw_q;
  logic        in_packet_q;
  logic        in_pre_q;
  logic [3:0]  pin_sync1_q;
  logic [3:0]  pin_sync2_q;

  logic [1:0] rx_bw;
  logic [1:0] asm_bw;
  logic       auto_en;
  logic       revert_en;
  assign rx_bw     = rx_filter_config_q[ccarx_pkg::RXBW_HI:ccarx_pkg::RXBW_LO];
  assign asm_bw    = assessment_filter_config_q[ccarx_pkg::ASMBW_HI:ccarx_pkg::ASMBW_LO];
  assign auto_en   = assessment_config_one_q[ccarx_pkg::AUTO_BIT];
  assign revert_en = assessment_config_one_q[ccarx_pkg::REVERT_BIT];

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  logic        aw_held_q;
  logic        w_held_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        wr_ok;
  logic [7:0]  wbyte;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wbyte         = w_data_q[7:0];
  assign wr_ok         = wr_fire && w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  logic wr_hit;
  always_comb begin
    case ({2'b00, aw_addr_q[11:2]})
      ccarx_pkg::ADDR_PROGRESS, ccarx_pkg::ADDR_RX_FILTER, ccarx_pkg::ADDR_ASM_FILTER,
      ccarx_pkg::ADDR_ASM_CFG1, ccarx_pkg::ADDR_PIN_CTRL, ccarx_pkg::ADDR_CMD,
      ccarx_pkg::ADDR_STATUS, ccarx_pkg::ADDR_IRQ_STAT, ccarx_pkg::ADDR_IRQ_CLR,
      ccarx_pkg::ADDR_IRQ_EN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic wr_to(input logic [11:0] a);
    wr_to = wr_ok && ({2'b00, aw_addr_q[11:2]} == a);
  endfunction

  // Config registers; progress byte write is dropped on purpose
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_filter_config_q         <= ccarx_pkg::RST_RX_FILTER;
      assessment_filter_config_q <= ccarx_pkg::RST_ASM_FILTER;
      assessment_config_one_q    <= ccarx_pkg::RST_ASM_CFG1;
      antenna_pin_control_q      <= ccarx_pkg::RST_PIN_CTRL;
      irq_en_q                   <= '0;
    end else begin
      if (wr_to(ccarx_pkg::ADDR_RX_FILTER))  rx_filter_config_q <= wbyte;
      if (wr_to(ccarx_pkg::ADDR_ASM_FILTER)) assessment_filter_config_q <= wbyte;
      if (wr_to(ccarx_pkg::ADDR_ASM_CFG1))   assessment_config_one_q <= wbyte;
      if (wr_to(ccarx_pkg::ADDR_PIN_CTRL))   antenna_pin_control_q <= wbyte;
      if (wr_to(ccarx_pkg::ADDR_IRQ_EN))     irq_en_q <= wbyte[ccarx_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // Commands
  // ----------------------------------------
  logic cmd_wr;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_enter;
  logic cmd_tx;
  logic cmd_idle;
  assign cmd_wr    = wr_to(ccarx_pkg::ADDR_CMD);
  assign cmd_start = cmd_wr && wbyte == ccarx_pkg::CMD_ASM_START;
  assign cmd_stop  = cmd_wr && wbyte == ccarx_pkg::CMD_ASM_STOP;
  assign cmd_enter = cmd_wr && wbyte == ccarx_pkg::CMD_ENTER_RX;
  assign cmd_tx    = cmd_wr && wbyte == ccarx_pkg::CMD_ENTER_TX;
  assign cmd_idle  = cmd_wr && wbyte == ccarx_pkg::CMD_IDLE_ON;

  logic in_rx;
  assign in_rx = state_q == ccarx_pkg::CCARX_RX;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ccarx_pkg::CCARX_IDLE;
    end else begin
      case (state_q)
        ccarx_pkg::CCARX_IDLE, ccarx_pkg::CCARX_RX, ccarx_pkg::CCARX_TX: begin
          if (cmd_enter) state_q <= ccarx_pkg::CCARX_RX;
          else if (cmd_tx) state_q <= ccarx_pkg::CCARX_TX;
          else if (cmd_idle) state_q <= ccarx_pkg::CCARX_IDLE;
        end
        default: state_q <= ccarx_pkg::CCARX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Packet tracking
  // ----------------------------------------
  // A restart mid-preamble drops the half-acquired preamble with the progress bits
  logic restart;
  assign restart = cmd_enter || cmd_start;

  always_ff @(posedge aclk) begin
    if (!aresetn || restart || !in_rx) begin
      in_pre_q    <= 1'b0;
      in_packet_q <= 1'b0;
    end else begin
      if (rx_evt.preamble) in_pre_q <= 1'b1;
      if (rx_evt.sfd) begin
        in_pre_q    <= 1'b0;
        in_packet_q <= 1'b1;
      end
      if (rx_evt.false_pre) in_pre_q <= 1'b0;
      if (rx_evt.packet_end) in_packet_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Filter bandwidth selection
  // ----------------------------------------
  // Revert clear blocks the timer-expiry restore while a preamble or packet is live
  logic bw_hold;
  assign bw_hold = !revert_en && (in_pre_q || in_packet_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_bw_q <= 2'h0;
    end else if (cmd_enter) begin
      filter_bw_q <= rx_bw;
    end else if (in_rx) begin
      if (cmd_start && auto_en) begin
        filter_bw_q <= asm_bw;
      end else if (cmd_stop) begin
        filter_bw_q <= rx_bw;
      end else if (rx_evt.false_pre) begin
        filter_bw_q <= auto_en ? asm_bw : rx_bw;
      end else if (rx_evt.preamble && revert_en) begin
        filter_bw_q <= rx_bw;
      end else if (rx_evt.packet_end) begin
        filter_bw_q <= rx_bw;
      end else if (rx_evt.timer_exp && !bw_hold) begin
        filter_bw_q <= rx_bw;
      end
    end
  end

  assign filter_bw = filter_bw_q;
  assign if_300k   = filter_bw_q >= ccarx_pkg::BW_IF300_MIN;

  // ----------------------------------------
  // Receive progress byte
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      rx_progress_flags_q <= 3'h0;
    end else if (in_rx) begin
      if (rx_evt.false_pre) begin
        rx_progress_flags_q <= 3'h0;
      end else begin
        if (rx_evt.preamble) rx_progress_flags_q[ccarx_pkg::PRG_PRE] <= 1'b1;
        if (rx_evt.sfd)      rx_progress_flags_q[ccarx_pkg::PRG_SFD] <= 1'b1;
        if (rx_evt.crc_ok)   rx_progress_flags_q[ccarx_pkg::PRG_CRC] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [ccarx_pkg::IRQ_W-1:0] irq_set;
  logic [ccarx_pkg::IRQ_W-1:0] irq_clr;
  assign irq_set = in_rx ? {rx_evt.false_pre, rx_evt.crc_ok, rx_evt.sfd, rx_evt.preamble}
                         : '0;
  assign irq_clr = wr_to(ccarx_pkg::ADDR_IRQ_CLR) ? wbyte[ccarx_pkg::IRQ_W-1:0] : '0;

  // Set beats clear in the same cycle so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // ----------------------------------------
  // Antenna pins
  // ----------------------------------------
  ccarx_pkg::ccarx_pins_type pins;
  ccarx_pins u_pins (
    .active   (in_rx),
    .pin_ctrl (antenna_pin_control_q),
    .pins     (pins)
  );
  assign ant_pin_out = pins.level;
  assign ant_pin_oe  = pins.oe;

  // Pin readback for status, synchronised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync1_q <= 4'h0;
      pin_sync2_q <= 4'h0;
    end else begin
      pin_sync1_q <= ant_pin_in;
      pin_sync2_q <= pin_sync1_q;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({2'b00, s_axi_araddr[11:2]})
      ccarx_pkg::ADDR_PROGRESS:   rd_mux[2:0] = rx_progress_flags_q;
      ccarx_pkg::ADDR_RX_FILTER:  rd_mux[7:0] = rx_filter_config_q;
      ccarx_pkg::ADDR_ASM_FILTER: rd_mux[7:0] = assessment_filter_config_q;
      ccarx_pkg::ADDR_ASM_CFG1:   rd_mux[7:0] = assessment_config_one_q;
      ccarx_pkg::ADDR_PIN_CTRL:   rd_mux[7:0] = antenna_pin_control_q;
      ccarx_pkg::ADDR_CMD:        rd_mux = 32'h0000_0000;
      ccarx_pkg::ADDR_STATUS:
        rd_mux[11:0] = {pin_sync2_q, in_packet_q, in_pre_q, if_300k, filter_bw_q, state_q};
      ccarx_pkg::ADDR_IRQ_STAT:   rd_mux[ccarx_pkg::IRQ_W-1:0] = irq_stat_q;
      ccarx_pkg::ADDR_IRQ_CLR:    rd_mux = 32'h0000_0000;
      ccarx_pkg::ADDR_IRQ_EN:     rd_mux[ccarx_pkg::IRQ_W-1:0] = irq_en_q;
      default:                    rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_ENTER_BW: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_enter |=> filter_bw == $past(rx_bw)) else $error("entry bandwidth wrong");
  AST_START_BW: assert property (@(posedge aclk) disable iff (!aresetn)
    in_rx && cmd_start && auto_en |=> filter_bw == $past(asm_bw))
    else $error("start bandwidth wrong");
  AST_IF_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
    if_300k == (filter_bw == 2'h3)) else $error("IF select wrong");
  AST_STOP_BW: assert property (@(posedge aclk) disable iff (!aresetn)
    in_rx && cmd_stop && !cmd_enter |=> filter_bw == $past(rx_bw))
    else $error("stop bandwidth wrong");
  AST_PRE_REVERT: assert property (@(posedge aclk) disable iff (!aresetn)
    in_rx && !cmd_wr && rx_evt == 6'b100000 && revert_en |=> filter_bw == $past(rx_bw))
    else $error("preamble revert missing");
  AST_HOLD_BW: assert property (@(posedge aclk) disable iff (!aresetn)
    bw_hold && !cmd_wr && !rx_evt.false_pre && !rx_evt.packet_end |=> $stable(filter_bw))
    else $error("bandwidth changed during preamble");
  AST_FALSE_BW: assert property (@(posedge aclk) disable iff (!aresetn)
    in_rx && !cmd_wr && rx_evt.false_pre |=> filter_bw == ($past(auto_en) ? $past(asm_bw)
    : $past(rx_bw))) else $error("false preamble bandwidth wrong");
  AST_PROG_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    restart |=> rx_progress_flags_q == 3'h0) else $error("progress not cleared");
  AST_FALSE_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    in_rx && rx_evt.false_pre |=> rx_progress_flags_q == 3'h0)
    else $error("false preamble kept progress");
  AST_SFD_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    in_rx && !restart && rx_evt.sfd && !rx_evt.false_pre |=> rx_progress_flags_q[1])
    else $error("sfd flag not set");
  AST_PROG_RO: assert property (@(posedge aclk) disable iff (!aresetn)
    !in_rx && !restart |=> $stable(rx_progress_flags_q)) else $error("progress byte moved");
  AST_PINS: assert property (@(posedge aclk) disable iff (!aresetn)
    in_rx |-> ant_pin_oe == (antenna_pin_control_q[5] ? 4'hc : 4'h3))
    else $error("pin enables wrong");
  CV_START: cover property (@(posedge aclk) disable iff (!aresetn) in_rx && cmd_start && auto_en);
  CV_FALSE: cover property (@(posedge aclk) disable iff (!aresetn) in_rx && rx_evt.false_pre);
  CV_PKT: cover property (@(posedge aclk) disable iff (!aresetn) rx_progress_flags_q == 3'h7);
  CV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) irq);

endmodule

// File: rtl/ccarx_pins.sv
`timescale 1ns/1ps
module ccarx_pins (
  // Control
  input  wire logic                     active,
  input  wire logic [7:0]               pin_ctrl,
  // Pins
  output      ccarx_pkg::ccarx_pins_type pins
);
  logic [1:0] lvl;
  logic       sel;
  assign lvl = pin_ctrl[ccarx_pkg::PIN_LVL_HI:ccarx_pkg::PIN_LVL_LO];
  assign sel = pin_ctrl[ccarx_pkg::PIN_SEL_BIT];

  // Pin one/three carry bit 7, two/four bit 6
  always_comb begin
    pins.level = {lvl[0], lvl[1], lvl[0], lvl[1]};
    pins.oe    = 4'h0;
    if (active) begin
      pins.oe = sel ? 4'hc : 4'h3;
    end
  end
endmodule

// File: rtl/ccarx_pkg.sv
// Overview of operation
// - Entering assessment receive loads filter bandwidth from receive config bits 7:6.
// - With auto-switch set, assessment start selects assessment bandwidth bits 6:5.
// - Intermediate frequency follows the selected bandwidth: 200 kHz or 300 kHz.
// - Timer expiry, stop command or re-entry restores the stored receive bandwidth.
// - Revert-on-preamble set: preamble detection restores receive bandwidth for the packet.
// - Revert clear: bandwidth held through the packet, restored after packet end.
// - After a false preamble pick assessment bandwidth if auto-switch, else receive.
// - Revert clear: timer expiry never changes bandwidth during a detected preamble.
// - Progress byte: bit 0 preamble, bit 1 SFD, bit 2 good CRC.
// - Progress bits clear on entry, then each sets on its own event.
// - A qualified preamble without SFD clears progress bits; search continues.
// - Any command that restarts reception clears all progress bits.
// - Qualification lands 1 to 4 bytes into preamble; early commands may lose packets.
// - In assessment receive, antenna pins driven from pin control bits 7:5.
// - Select 0 drives pins one/two from bits 7:6; select 1 drives three/four.
package ccarx_pkg;

  // ----------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------
  localparam logic [11:0] ADDR_PROGRESS   = 12'h01f;
  localparam logic [11:0] ADDR_RX_FILTER  = 12'h115;
  localparam logic [11:0] ADDR_ASM_FILTER = 12'h129;
  localparam logic [11:0] ADDR_ASM_CFG1   = 12'h12a;
  localparam logic [11:0] ADDR_PIN_CTRL   = 12'h12d;
  localparam logic [11:0] ADDR_CMD        = 12'h200;
  localparam logic [11:0] ADDR_STATUS     = 12'h204;
  localparam logic [11:0] ADDR_IRQ_STAT   = 12'h208;
  localparam logic [11:0] ADDR_IRQ_CLR    = 12'h20c;
  localparam logic [11:0] ADDR_IRQ_EN     = 12'h210;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RXBW_HI     = 7;
  localparam int RXBW_LO     = 6;
  localparam int ASMBW_HI    = 6;
  localparam int ASMBW_LO    = 5;
  localparam int AUTO_BIT    = 5;
  localparam int REVERT_BIT  = 4;
  localparam int PIN_LVL_HI  = 7;
  localparam int PIN_LVL_LO  = 6;
  localparam int PIN_SEL_BIT = 5;
  localparam int PRG_PRE     = 0;
  localparam int PRG_SFD     = 1;
  localparam int PRG_CRC     = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_RX_FILTER  = 8'h00;
  localparam logic [7:0] RST_ASM_FILTER = 8'h00;
  localparam logic [7:0] RST_ASM_CFG1   = 8'h00;
  localparam logic [7:0] RST_PIN_CTRL   = 8'h00;

  // ----------------------------------------
  // Commands
  // ----------------------------------------
  localparam logic [7:0] CMD_ASM_START = 8'hb7;
  localparam logic [7:0] CMD_ASM_STOP  = 8'hb8;
  localparam logic [7:0] CMD_ENTER_RX  = 8'hb9;
  localparam logic [7:0] CMD_ENTER_TX  = 8'hba;
  localparam logic [7:0] CMD_IDLE_ON   = 8'hbb;

  // Bandwidth codes at or above this use the 300 kHz IF
  localparam logic [1:0] BW_IF300_MIN = 2'h3;
  localparam int         IF_LOW_KHZ   = 200;
  localparam int         IF_HIGH_KHZ  = 300;

  // Irq event bits
  localparam int IRQ_W      = 4;
  localparam int IRQ_PRE    = 0;
  localparam int IRQ_SFD    = 1;
  localparam int IRQ_CRC    = 2;
  localparam int IRQ_FALSE  = 3;

  typedef enum logic [2:0] {
    CCARX_IDLE = 3'b001,
    CCARX_RX   = 3'b010,
    CCARX_TX   = 3'b100
  } ccarx_state_type;

  typedef struct packed {
    logic preamble;
    logic sfd;
    logic crc_ok;
    logic packet_end;
    logic false_pre;
    logic timer_exp;
  } ccarx_event_type;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } ccarx_pins_type;

endpackage

// File: tb/ccarx_ctrl_tb_top.sv
`timescale 1ns/1ps
module ccarx_ctrl_tb_top;
  logic                       aclk;
  logic                       aresetn;
  logic [11:0]                awaddr, araddr;
  logic                       awvalid, awready, wvalid, wready, bvalid, bready;
  logic                       arvalid, arready, rvalid, rready;
  logic [31:0]                wdata, rdata, rd_data;
  logic [1:0]                 bresp, rresp, rd_resp, filter_bw;
  ccarx_pkg::ccarx_event_type rx_evt;
  logic                       if_300k, irq;
  logic [3:0]                 ant_pin_out, ant_pin_oe;
  int                         fail_count, n_tests;
  // Pin control byte, expected enables, expected driven levels
  logic [15:0]                rows [8] = '{16'h0e30, 16'h4032, 16'h8031, 16'hc033,
                                           16'h20c0, 16'h60c8, 16'ha0c4, 16'he0cc};

  ccarx_host_model ccarx_host_model_inst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  ccarx_ctrl ccarx_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_evt(rx_evt),
    .filter_bw(filter_bw), .if_300k(if_300k), .ant_pin_out(ant_pin_out),
    .ant_pin_oe(ant_pin_oe), .ant_pin_in(4'h5), .irq(irq));

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Printed offsets are word indices, so the byte address is four times larger
  function automatic logic [11:0] ra(input logic [11:0] idx);
    return {idx[9:0], 2'b00};
  endfunction

  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    ccarx_host_model_inst.wr(a, {24'h0, d}, r);
    @(negedge aclk);
  endtask

  task automatic cmd(input logic [7:0] c);
    wreg(ra(ccarx_pkg::ADDR_CMD), c);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    ccarx_host_model_inst.rd(a, rd_data, rd_resp);
    chk(nm, rd_data, exp);
  endtask

  // Event order in the struct: preamble, sfd, crc_ok, packet_end, false_pre, timer_exp
  task automatic pulse(input logic [5:0] e);
    @(posedge aclk);
    rx_evt <= ccarx_pkg::ccarx_event_type'(e);
    @(posedge aclk);
    rx_evt <= '0;
    @(negedge aclk);
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    final_report();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    aresetn = 1'b0;
    rx_evt = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("oe_reset", ant_pin_oe, 4'h0);
    chk("irq_reset", irq, 1'b0);
    rchk("rx_filter_reset", ra(ccarx_pkg::ADDR_RX_FILTER), {24'h0, ccarx_pkg::RST_RX_FILTER});
    wreg(ra(ccarx_pkg::ADDR_RX_FILTER), 8'h80);
    wreg(ra(ccarx_pkg::ADDR_ASM_FILTER), 8'h60);
    wreg(ra(ccarx_pkg::ADDR_ASM_CFG1), 8'h20);
    cmd(ccarx_pkg::CMD_ENTER_RX);
    chk("bw_entry", filter_bw, 2'h2);
    chk("if_entry", if_300k, 1'b0);
    rchk("progress_entry", ra(ccarx_pkg::ADDR_PROGRESS), 32'h0);
    for (int i = 0; i < 8; i++) begin
      wreg(ra(ccarx_pkg::ADDR_PIN_CTRL), rows[i][15:8]);
      chk("pin_oe", ant_pin_oe, rows[i][7:4]);
      chk("pin_out", ant_pin_out & ant_pin_oe, rows[i][3:0]);
    end
    // Commands are issued only while no preamble is in flight
    rchk("progress_idle", ra(ccarx_pkg::ADDR_PROGRESS), 32'h0);
    cmd(ccarx_pkg::CMD_ASM_START);
    chk("bw_start", filter_bw, 2'h3);
    chk("if_start", if_300k, 1'b1);
    wreg(ra(ccarx_pkg::ADDR_IRQ_EN), 8'h01);
    pulse(6'h20);
    chk("bw_hold_pre", filter_bw, 2'h3);
    chk("irq_pre", irq, 1'b1);
    rchk("progress_pre", ra(ccarx_pkg::ADDR_PROGRESS), 32'h1);
    pulse(6'h10);
    pulse(6'h08);
    rchk("progress_all", ra(ccarx_pkg::ADDR_PROGRESS), 32'h7);
    wreg(ra(ccarx_pkg::ADDR_PROGRESS), 8'h00);
    rchk("progress_wr", ra(ccarx_pkg::ADDR_PROGRESS), 32'h7);
    chk("bw_in_pkt", filter_bw, 2'h3);
    pulse(6'h04);
    chk("bw_pkt_end", filter_bw, 2'h2);
    wreg(ra(ccarx_pkg::ADDR_IRQ_EN), 8'h00);
    chk("irq_masked", irq, 1'b0);
    rchk("irq_stat", ra(ccarx_pkg::ADDR_IRQ_STAT), 32'h7);
    wreg(ra(ccarx_pkg::ADDR_IRQ_CLR), 8'h0f);
    rchk("irq_cleared", ra(ccarx_pkg::ADDR_IRQ_STAT), 32'h0);
    cmd(ccarx_pkg::CMD_ASM_START);
    cmd(ccarx_pkg::CMD_ENTER_RX);
    chk("bw_reenter", filter_bw, 2'h2);
    rchk("progress_restart", ra(ccarx_pkg::ADDR_PROGRESS), 32'h0);
    cmd(ccarx_pkg::CMD_ASM_START);
    pulse(6'h20);
    pulse(6'h02);
    rchk("progress_false", ra(ccarx_pkg::ADDR_PROGRESS), 32'h0);
    chk("bw_false_auto", filter_bw, 2'h3);
    cmd(ccarx_pkg::CMD_ASM_STOP);
    chk("bw_stop", filter_bw, 2'h2);
    // Revert is only set with both bandwidths on the lower IF
    wreg(ra(ccarx_pkg::ADDR_ASM_FILTER), 8'h20);
    wreg(ra(ccarx_pkg::ADDR_ASM_CFG1), 8'h30);
    cmd(ccarx_pkg::CMD_ASM_START);
    chk("bw_start_low", filter_bw, 2'h1);
    pulse(6'h20);
    chk("bw_revert", filter_bw, 2'h2);
    pulse(6'h02);
    chk("bw_revert_false", filter_bw, 2'h1);
    pulse(6'h01);
    chk("bw_timer", filter_bw, 2'h2);
    wreg(ra(ccarx_pkg::ADDR_ASM_CFG1), 8'h10);
    cmd(ccarx_pkg::CMD_ASM_START);
    pulse(6'h20);
    pulse(6'h02);
    chk("bw_false_noauto", filter_bw, 2'h2);
    // Pins, idle flags, bandwidth code 2 and receive state
    rchk("status", ra(ccarx_pkg::ADDR_STATUS), 32'h512);
    // Reset in mid-run while receiving
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("bw_rerun", filter_bw, 2'h0);
    chk("oe_rerun", ant_pin_oe, 4'h0);
    rchk("rx_filter_rerun", ra(ccarx_pkg::ADDR_RX_FILTER), {24'h0, ccarx_pkg::RST_RX_FILTER});
    ccarx_host_model_inst.rd(12'h3f0, rd_data, rd_resp);
    chk("unmapped_resp", rd_resp, 2'b10);
    final_report();
  end
endmodule

// File: tb/ccarx_host_model.sv
`timescale 1ns/1ps
module ccarx_host_model (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output      logic [11:0] awaddr,
  output      logic        awvalid,
  input  wire logic        awready,
  output      logic [31:0] wdata,
  output      logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output      logic        bready,
  // Read channels
  output      logic [11:0] araddr,
  output      logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output      logic        rready
);
  // ----------------------------------------
  // Bus master cycles
  // ----------------------------------------
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Released payloads show the inverse so a stale value cannot pass for a live one
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule
